// ### adc_cfg_consts.vh
/*
  Constants of the converter configuration register block: register
  addresses, field positions, page codes, reset values and the layout of the
  serial control frame.
  Assumes it is included by its bare name by the design file that needs it.
*/
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH

// Register addresses within the 12-bit serial address space.
`define ADDR_SOFT_RESET 12'h000
`define ADDR_LINK_PAGE_LO 12'h003
`define ADDR_LINK_PAGE_HI 12'h004
`define ADDR_PAIR_WRITE 12'h005
`define ADDR_ANALOG_PAGE 12'h011
`define ADDR_CORE_MASK_ONE 12'h020
`define ADDR_BUF_MASK_ONE 12'h021
`define ADDR_CORE_MASK_TWO 12'h023
`define ADDR_BUF_MASK_TWO 12'h024
`define ADDR_SLEEP_CTRL 12'h026
`define ADDR_MASK_CTRL 12'h055

// Address spaces by upper address nibble, and the lowest master register address.
`define SPACE_GENERAL 4'h0
`define SPACE_LINK_WINDOW 4'h6
`define LOW_MASTER_ADDR 8'h20

// Page codes.
`define LINK_PAGE_MAIN 16'h6800
`define LINK_PAGE_DIGITAL 16'h6900
`define LINK_PAGE_ANALOG 16'h6A00
`define ANALOG_PAGE_MASTER 8'h80
`define ANALOG_PAGE_ADC 8'h0F

// Field positions.
`define RESET_BIT_HI 7
`define RESET_BIT_LO 0
`define PAIR_OFF_BIT 0
`define CORE_A_HI 7
`define CORE_A_LO 4
`define CORE_B_HI 3
`define CORE_B_LO 0
`define BUF_B_HI 7
`define BUF_B_LO 6
`define BUF_A_HI 5
`define BUF_A_LO 4
`define GLOBAL_SLEEP_BIT 7
`define PIN_IGNORE_BIT 6
`define MASK_CHOICE_BIT 5
`define MASK_ENABLE_BIT 4

// Reset values.
`define RST_BYTE 8'h00
`define RST_PAGE 16'h0000
`define RST_SYNC 4'h1
`define BYTE_ZERO 8'h00

// Serial frame layout: read flag, channel bit, 12-bit address, 8-bit data.
`define FRAME_LAST 5'd23
`define HEADER_LAST 5'd15
`define HEADER_DONE 5'd16
`define CNT_ZERO 5'd0
`define CNT_ONE 5'd1
`define FRAME_RW_BIT 23
`define FRAME_CH_BIT 20
`define FRAME_ADDR_HI 19
`define FRAME_ADDR_LO 8

`endif

// ### adc_page_select_regs.v
/*
  Configuration register bank of a dual-channel converter: soft reset,
  link bank page number, channel pair-write control, analog bank page and
  the two power-down masks, reached over a host-clocked serial port.
  Assumes the serial clock runs well below a quarter of sys_clk, since all
  serial pins are sampled through two flip-flops.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adc_cfg_consts.vh"

module adc_page_select_regs (
  input wire sys_clk,
  input wire arst_n,
  input wire serEnableN,
  input wire serClk,
  input wire serDataIn,
  output wire serDataOut,
  output wire serDataOutEn,
  input wire sleepPin,
  output reg softResetPulse,
  output wire [15:0] linkBankPageNumber,
  output wire [2:0] linkPageSelect,
  output wire [7:0] analogBankPage,
  output wire pairWriteOff,
  output reg chanWriteA,
  output reg chanWriteB,
  output reg [11:0] chanWriteAddr,
  output reg [7:0] chanWriteData,
  output reg [3:0] coreSleepA,
  output reg [3:0] coreSleepB,
  output reg [1:0] bufferSleepA,
  output reg [1:0] bufferSleepB,
  output reg wholeChipSleep
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // Reset level of each synchroniser: select idles high, the other pins low.
  localparam [3:0] SYNC_RST = `RST_SYNC;

  wire [3:0] pinRaw;
  wire [3:0] pinSync;
  assign pinRaw = {sleepPin, serDataIn, serClk, serEnableN};

  // Each pin passes two flip-flops; only the second stage is read.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_sync
      reg stageOneQ;
      reg stageTwoQ;
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          stageOneQ <= SYNC_RST[g];
          stageTwoQ <= SYNC_RST[g];
        end else begin
          stageOneQ <= pinRaw[g];
          stageTwoQ <= stageOneQ;
        end
      end
      assign pinSync[g] = stageTwoQ;
    end
  endgenerate

  wire selN = pinSync[0];
  wire sclkS = pinSync[1];
  wire sdinS = pinSync[2];
  wire sleepPinS = pinSync[3];

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine.

  reg sclkPrevQ;
  reg [4:0] bitCntQ;
  reg [23:0] frameQ;
  reg [7:0] outShiftQ;
  reg isReadQ;
  wire sclkRise = sclkS & ~sclkPrevQ & ~selN;
  wire sclkFall = ~sclkS & sclkPrevQ & ~selN;
  wire [23:0] frameNext = {frameQ[22:0], sdinS};
  // Carry bit kept so the increment is sized on purpose.
  wire [5:0] bitCntInc = bitCntQ + `CNT_ONE;
  wire frameDone = sclkRise && (bitCntQ == `FRAME_LAST) && !isReadQ;
  wire headerDone = sclkRise && (bitCntQ == `HEADER_LAST);
  wire [11:0] wrAddr = frameNext[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  wire [7:0] wrData = frameNext[7:0];
  wire wrChan = frameNext[`FRAME_CH_BIT];
  // Header is complete when headerDone fires: frameNext holds it in bits 15:0.
  wire [11:0] rdAddr = frameNext[11:0];
  wire rdFlag = frameNext[15];

  // Counts bits of a frame; deselect restarts the frame.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrevQ <= 1'b0;
      bitCntQ <= `CNT_ZERO;
      frameQ <= 24'h00_0000;
      isReadQ <= 1'b0;
    end else begin
      sclkPrevQ <= sclkS;
      if (selN) begin
        bitCntQ <= `CNT_ZERO;
        isReadQ <= 1'b0;
      end else if (sclkRise) begin
        frameQ <= frameNext;
        if (bitCntQ != `FRAME_LAST)
          bitCntQ <= bitCntInc[4:0];
        else
          bitCntQ <= `CNT_ZERO;
        if (headerDone)
          isReadQ <= rdFlag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  reg [15:0] linkPageQ;
  reg pairOffQ;
  reg [7:0] analogPageQ;
  reg [7:0] coreMaskOneQ;
  reg [3:0] bufMaskOneQ;
  reg [7:0] coreMaskTwoQ;
  reg [3:0] bufMaskTwoQ;
  reg globalSleepQ;
  reg pinIgnoreQ;
  reg maskChoiceQ;
  reg maskEnableQ;

  // Master page registers are decoded only while the master page is chosen.
  wire masterPage = (analogPageQ == `ANALOG_PAGE_MASTER);
  wire adcPage = (analogPageQ == `ANALOG_PAGE_ADC);
  wire wrGeneral = frameDone && (wrAddr[11:8] == `SPACE_GENERAL);
  wire wrMaster = wrGeneral && masterPage;
  wire softResetHit = wrGeneral && (wrAddr == `ADDR_SOFT_RESET) &&
    (wrData[`RESET_BIT_HI] | wrData[`RESET_BIT_LO]);

  // Stores the documented fields; reserved bits are dropped.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      linkPageQ <= `RST_PAGE;
      pairOffQ <= 1'b0;
      analogPageQ <= `RST_BYTE;
      coreMaskOneQ <= `RST_BYTE;
      bufMaskOneQ <= 4'h0;
      coreMaskTwoQ <= `RST_BYTE;
      bufMaskTwoQ <= 4'h0;
      globalSleepQ <= 1'b0;
      pinIgnoreQ <= 1'b0;
      maskChoiceQ <= 1'b0;
      maskEnableQ <= 1'b0;
    end else if (softResetHit) begin
      linkPageQ <= `RST_PAGE;
      pairOffQ <= 1'b0;
      analogPageQ <= `RST_BYTE;
      coreMaskOneQ <= `RST_BYTE;
      bufMaskOneQ <= 4'h0;
      coreMaskTwoQ <= `RST_BYTE;
      bufMaskTwoQ <= 4'h0;
      globalSleepQ <= 1'b0;
      pinIgnoreQ <= 1'b0;
      maskChoiceQ <= 1'b0;
      maskEnableQ <= 1'b0;
    end else begin
      if (wrGeneral && wrAddr == `ADDR_LINK_PAGE_LO)
        linkPageQ[7:0] <= wrData;
      if (wrGeneral && wrAddr == `ADDR_LINK_PAGE_HI)
        linkPageQ[15:8] <= wrData;
      if (wrGeneral && wrAddr == `ADDR_PAIR_WRITE)
        pairOffQ <= wrData[`PAIR_OFF_BIT];
      if (wrGeneral && wrAddr == `ADDR_ANALOG_PAGE)
        analogPageQ <= wrData;
      if (wrMaster && wrAddr == `ADDR_CORE_MASK_ONE)
        coreMaskOneQ <= wrData;
      if (wrMaster && wrAddr == `ADDR_BUF_MASK_ONE)
        bufMaskOneQ <= wrData[`BUF_B_HI:`BUF_A_LO];
      if (wrMaster && wrAddr == `ADDR_CORE_MASK_TWO)
        coreMaskTwoQ <= wrData;
      if (wrMaster && wrAddr == `ADDR_BUF_MASK_TWO)
        bufMaskTwoQ <= wrData[`BUF_B_HI:`BUF_A_LO];
      if (wrMaster && wrAddr == `ADDR_SLEEP_CTRL) begin
        pinIgnoreQ <= wrData[`PIN_IGNORE_BIT];
        maskChoiceQ <= wrData[`MASK_CHOICE_BIT];
        // Global sleep only takes a new value once pin ignore is already set.
        if (pinIgnoreQ)
          globalSleepQ <= wrData[`GLOBAL_SLEEP_BIT];
      end
      if (wrMaster && wrAddr == `ADDR_MASK_CTRL)
        maskEnableQ <= wrData[`MASK_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel forwarding of paged writes.

  // Link window writes and ADC page writes go to the channel logic.
  wire fwdWrite = frameDone && !softResetHit &&
    ((wrAddr[11:8] == `SPACE_LINK_WINDOW) ||
     ((wrAddr[11:8] == `SPACE_GENERAL) && adcPage &&
      (wrAddr[7:0] >= `LOW_MASTER_ADDR)));

  // Pair mode hits both channels; otherwise the channel bit picks one.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chanWriteA <= 1'b0;
      chanWriteB <= 1'b0;
      chanWriteAddr <= 12'h000;
      chanWriteData <= `BYTE_ZERO;
      softResetPulse <= 1'b0;
    end else begin
      chanWriteA <= fwdWrite && (!pairOffQ || !wrChan);
      chanWriteB <= fwdWrite && (!pairOffQ || wrChan);
      softResetPulse <= softResetHit;
      if (fwdWrite) begin
        chanWriteAddr <= wrAddr;
        chanWriteData <= wrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down outputs.

  reg [7:0] coreSel;
  reg [3:0] bufSel;
  reg [3:0] coreAD;
  reg [3:0] coreBD;
  reg [1:0] bufAD;
  reg [1:0] bufBD;

  // Chooses a mask, then gates it with the mask control bit.
  always @* begin
    coreSel = maskChoiceQ ? coreMaskTwoQ : coreMaskOneQ;
    bufSel = maskChoiceQ ? bufMaskTwoQ : bufMaskOneQ;
    coreAD = 4'h0;
    coreBD = 4'h0;
    bufAD = 2'b00;
    bufBD = 2'b00;
    if (maskEnableQ) begin
      coreAD = coreSel[`CORE_A_HI:`CORE_A_LO];
      coreBD = coreSel[`CORE_B_HI:`CORE_B_LO];
      // Buffer codes pass as stored: 00 active, 11 both down.
      bufBD = bufSel[3:2];
      bufAD = bufSel[1:0];
    end
  end

  // Registers the power-down controls; pin ignore hands sleep to software.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      coreSleepA <= 4'h0;
      coreSleepB <= 4'h0;
      bufferSleepA <= 2'b00;
      bufferSleepB <= 2'b00;
      wholeChipSleep <= 1'b0;
    end else begin
      coreSleepA <= coreAD;
      coreSleepB <= coreBD;
      bufferSleepA <= bufAD;
      bufferSleepB <= bufBD;
      wholeChipSleep <= pinIgnoreQ ? globalSleepQ : sleepPinS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page decode outputs.

  reg [2:0] pageSelQ;

  // One-hot, registered: bit 0 main digital, bit 1 link digital, bit 2 link analog.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pageSelQ <= 3'b000;
    end else begin
      pageSelQ <= {linkPageQ == `LINK_PAGE_ANALOG,
        linkPageQ == `LINK_PAGE_DIGITAL, linkPageQ == `LINK_PAGE_MAIN};
    end
  end

  assign linkBankPageNumber = linkPageQ;
  assign linkPageSelect = pageSelQ;
  assign analogBankPage = analogPageQ;
  assign pairWriteOff = pairOffQ;

  ////////////////////////////////////////////////////////////////////////////
  // Read-back.

  reg [7:0] rdByte;

  // Returns stored fields; reserved bits and write-only registers read zero.
  always @* begin
    rdByte = `BYTE_ZERO;
    if (rdAddr[11:8] == `SPACE_GENERAL) begin
      case (rdAddr)
        `ADDR_LINK_PAGE_LO: rdByte = linkPageQ[7:0];
        `ADDR_LINK_PAGE_HI: rdByte = linkPageQ[15:8];
        `ADDR_PAIR_WRITE: rdByte = {7'h00, pairOffQ};
        `ADDR_ANALOG_PAGE: rdByte = analogPageQ;
        default: rdByte = `BYTE_ZERO;
      endcase
      if (masterPage) begin
        case (rdAddr)
          `ADDR_CORE_MASK_ONE: rdByte = coreMaskOneQ;
          `ADDR_BUF_MASK_ONE: rdByte = {bufMaskOneQ, 4'h0};
          `ADDR_CORE_MASK_TWO: rdByte = coreMaskTwoQ;
          `ADDR_BUF_MASK_TWO: rdByte = {bufMaskTwoQ, 4'h0};
          `ADDR_SLEEP_CTRL: rdByte = {globalSleepQ, pinIgnoreQ, maskChoiceQ, 5'h00};
          `ADDR_MASK_CTRL: rdByte = {3'h0, maskEnableQ, 4'h0};
          default: rdByte = rdByte;
        endcase
      end
    end
  end

  // Loads after the header, shifts on each falling edge past the first.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      outShiftQ <= `BYTE_ZERO;
    end else if (headerDone && rdFlag) begin
      outShiftQ <= rdByte;
    end else if (sclkFall && isReadQ && bitCntQ > `HEADER_DONE) begin
      outShiftQ <= {outShiftQ[6:0], 1'b0};
    end
  end

  assign serDataOut = outShiftQ[7];
  assign serDataOutEn = isReadQ & ~selN;

endmodule // adc_page_select_regs
`default_nettype wire

// ### adc_regs_sva.sv
/* Checker of the converter configuration register block.
   Assumes it is bound to adc_page_select_regs and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module adc_regs_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic softResetPulse,
  input wire logic [15:0] linkBankPageNumber,
  input wire logic [2:0] linkPageSelect,
  input wire logic [7:0] analogBankPage,
  input wire logic pairWriteOff,
  input wire logic chanWriteA,
  input wire logic chanWriteB,
  input wire logic [11:0] chanWriteAddr,
  input wire logic [1:0] bufferSleepA,
  input wire logic [1:0] bufferSleepB
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // Pulses, page decode, pairing and field codes.
  soft_pulse_a: assert property (softResetPulse |=> !softResetPulse)
    else $error("Soft reset pulse too long.");
  soft_clear_a: assert property (softResetPulse |-> !pairWriteOff
    && linkBankPageNumber == 16'h0000 && analogBankPage == 8'h00)
    else $error("Fields not cleared by soft reset.");
  page_decode_a: assert property ($stable(linkBankPageNumber) |->
    linkPageSelect == {linkBankPageNumber == 16'h6A00,
    linkBankPageNumber == 16'h6900, linkBankPageNumber == 16'h6800})
    else $error("Page decode wrong.");
  pair_both_a: assert property (!pairWriteOff |-> chanWriteA == chanWriteB)
    else $error("Paired write reached one channel.");
  pair_single_a: assert property (pairWriteOff |-> !(chanWriteA && chanWriteB))
    else $error("Single write reached both channels.");
  write_pulse_a: assert property (chanWriteA || chanWriteB |=>
    !chanWriteA && !chanWriteB) else $error("Channel write pulse too long.");
  addr_hold_a: assert property ($changed(chanWriteAddr) |->
    (chanWriteA || chanWriteB) or ##[0:1] softResetPulse)
    else $error("Write address moved without a write.");
  buf_code_a: assert property (bufferSleepA[1] == bufferSleepA[0]
    && bufferSleepB[1] == bufferSleepB[0]) else $error("Illegal buffer code.");
  // Main scenarios.
  cover property (softResetPulse);
  cover property (chanWriteA && chanWriteB);
  cover property (chanWriteB && !chanWriteA);
endmodule // adc_regs_checker
bind adc_page_select_regs adc_regs_checker adc_regs_checker_i (.sys_clk(sys_clk),
  .arst_n(arst_n), .softResetPulse(softResetPulse), .analogBankPage(analogBankPage),
  .linkBankPageNumber(linkBankPageNumber), .linkPageSelect(linkPageSelect),
  .pairWriteOff(pairWriteOff), .chanWriteA(chanWriteA), .chanWriteB(chanWriteB),
  .chanWriteAddr(chanWriteAddr), .bufferSleepA(bufferSleepA),
  .bufferSleepB(bufferSleepB));
`default_nettype wire

// ### serial_host.sv
/* Host model driving 24-bit serial control frames, MSB first.
   Assumes a 25 MHz sys_clk; pins change at its falling edge. */
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  input wire logic sys_clk,
  input wire logic serDataOut,
  output logic serEnableN,
  output logic serClk,
  output logic serDataIn
);
  ////////////////////////////////////////
  // Idle: deselected, serial clock parked low.
  initial begin
    serEnableN = 1'b1;
    serClk = 1'b0;
    serDataIn = 1'b0;
  end
  // One frame; each serial phase lasts five sys_clk periods.
  task automatic frame(input logic [23:0] cmd, output logic [7:0] rdat);
    @(negedge sys_clk);
    serEnableN = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serDataIn = cmd[i];
      repeat (5) @(negedge sys_clk);
      if (i < 8) rdat[i] = serDataOut;
      serClk = 1'b1;
      repeat (5) @(negedge sys_clk);
      serClk = 1'b0;
    end
    repeat (5) @(negedge sys_clk);
    serEnableN = 1'b1;
    serDataIn = ~serDataIn; // A released line shows no stale value.
  endtask
endmodule // serial_host
`default_nettype wire

// ### test_adc_page_select_and_powerdown_regs.sv
/* Self-checking bench of the configuration register block.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR at %0t: got %h want %h", $time, a, b); end end
module test_adc_page_select_and_powerdown_regs;
  logic sys_clk = 1'b0, arst_n = 1'b0, sleepPin = 1'b0;
  logic serEnableN, serClk, serDataIn, serDataOut, softResetPulse, pairWriteOff;
  logic chanWriteA, chanWriteB, wholeChipSleep, serDataOutEn;
  logic [15:0] linkBankPageNumber;
  logic [2:0] linkPageSelect;
  logic [7:0] analogBankPage, chanWriteData, r;
  logic [11:0] chanWriteAddr;
  logic [3:0] coreSleepA, coreSleepB;
  logic [1:0] bufferSleepA, bufferSleepB;
  int compares = 0, num_errors = 0, cycles = 0, nA = 0, nB = 0, nRst = 0, nOe = 0;
  ////////////////////////////////////////
  serial_host serial_host_i (.sys_clk(sys_clk), .serDataOut(serDataOut),
    .serEnableN(serEnableN), .serClk(serClk), .serDataIn(serDataIn));
  adc_page_select_regs adc_page_select_regs_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .serEnableN(serEnableN), .serClk(serClk), .serDataIn(serDataIn),
    .serDataOut(serDataOut), .serDataOutEn(serDataOutEn), .sleepPin(sleepPin),
    .softResetPulse(softResetPulse), .linkBankPageNumber(linkBankPageNumber),
    .linkPageSelect(linkPageSelect), .analogBankPage(analogBankPage),
    .pairWriteOff(pairWriteOff), .chanWriteA(chanWriteA), .chanWriteB(chanWriteB),
    .chanWriteAddr(chanWriteAddr), .chanWriteData(chanWriteData),
    .coreSleepA(coreSleepA), .coreSleepB(coreSleepB), .bufferSleepA(bufferSleepA),
    .bufferSleepB(bufferSleepB), .wholeChipSleep(wholeChipSleep));
  // Clock, pulse counters and hang guard.
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    nA += chanWriteA;
    nB += chanWriteB;
    nRst += softResetPulse;
    nOe += serDataOutEn;
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end
  // Register write and read frames, then time for the update to land.
  task automatic wr(input logic ch, input logic [11:0] a, input logic [7:0] d);
    logic [7:0] x;
    serial_host_i.frame({3'b000, ch, a, d}, x);
    repeat (10) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    serial_host_i.frame({4'b1000, a, 8'h00}, d);
    repeat (10) @(negedge sys_clk);
  endtask
  // A forwarded write and the channel pulses it should raise.
  task automatic fwd(input logic ch, input logic [11:0] a, input logic [7:0] d,
    input int ea, input int eb);
    int a0 = nA, b0 = nB;
    wr(ch, a, d);
    `CHK(nA - a0, ea)
    `CHK(nB - b0, eb)
    `CHK({chanWriteAddr, chanWriteData}, {a, d})
  endtask
  ////////////////////////////////////////
  task automatic t_page();
    logic [7:0] hi[3] = '{8'h68, 8'h69, 8'h6A};
    int oe0;
    rd(12'h003, r);
    `CHK({r, linkBankPageNumber, pairWriteOff, analogBankPage}, 33'h0)
    wr(0, 12'h003, 8'h5A);
    wr(0, 12'h004, 8'h68);
    `CHK({linkBankPageNumber, linkPageSelect}, {16'h685A, 3'b000})
    wr(0, 12'h003, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(0, 12'h004, hi[i]);
      `CHK(linkPageSelect, 3'b001 << i)
    end
    oe0 = nOe;
    rd(12'h004, r);
    `CHK(r, 8'h6A)
    `CHK({nOe - oe0 > 80, serDataOutEn}, 2'b10)
    $display("test page done");
  endtask
  task automatic t_pair();
    fwd(1, 12'h641, 8'h16, 1, 1);
    wr(0, 12'h005, 8'h01);
    rd(12'h005, r);
    `CHK(r, 8'h01)
    fwd(1, 12'h632, 8'h0A, 0, 1);
    fwd(0, 12'h631, 8'h0B, 1, 0);
    wr(0, 12'h011, 8'h0F);
    fwd(1, 12'h020, 8'h0F, 0, 1);
    $display("test pair done");
  endtask
  task automatic t_mask();
    logic [7:0] c[3] = '{8'hF0, 8'h0F, 8'hFF};
    wr(0, 12'h011, 8'h80);
    `CHK(analogBankPage, 8'h80)
    wr(0, 12'h055, 8'h10);
    for (int i = 0; i < 3; i++) begin
      wr(0, 12'h020, c[i]);
      `CHK({coreSleepA, coreSleepB}, c[i])
    end
    wr(0, 12'h021, 8'h30);
    `CHK({bufferSleepB, bufferSleepA}, 4'b0011)
    wr(0, 12'h023, 8'h0F);
    wr(0, 12'h024, 8'hC0);
    `CHK({coreSleepA, coreSleepB}, 8'hFF)
    wr(0, 12'h026, 8'h20);
    `CHK({coreSleepA, coreSleepB, bufferSleepB, bufferSleepA}, 12'h0FC)
    wr(0, 12'h055, 8'h00);
    `CHK({coreSleepA, coreSleepB, bufferSleepB, bufferSleepA}, 12'h000)
    $display("test mask done");
  endtask
  task automatic t_sleep();
    sleepPin = 1'b1;
    wr(0, 12'h026, 8'h80);
    rd(12'h026, r);
    `CHK({r, wholeChipSleep}, {8'h00, 1'b1})
    wr(0, 12'h026, 8'h40);
    `CHK(wholeChipSleep, 1'b0)
    wr(0, 12'h026, 8'hC0);
    sleepPin = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK(wholeChipSleep, 1'b1)
    $display("test sleep done");
  endtask
  task automatic t_soft();
    wr(0, 12'h000, 8'h80);
    `CHK(nRst, 1)
    `CHK({analogBankPage, linkBankPageNumber, wholeChipSleep}, 25'h0)
    wr(0, 12'h011, 8'h80);
    wr(0, 12'h000, 8'h01);
    rd(12'h000, r);
    `CHK(nRst, 2)
    `CHK({r, analogBankPage}, 16'h0)
    $display("test soft reset done");
  endtask
  // Verdict and end of run.
  task automatic test_done();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_page();
    t_pair();
    t_mask();
    t_sleep();
    t_soft();
    test_done();
  end
endmodule // test_adc_page_select_and_powerdown_regs
`default_nettype wire
